/* hw/baud_pkg.sv */
// Purpose: shared constants and types for the serial line baud clock block
// Assumes: pclk at 200 MHz; APB register window of 8 address bits
// Notes: times are kept in their own unit, cycle counts derive from them
package baud_pkg;

  localparam int CLK_PERIOD_PS = 5000;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_down(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // oscillator and strobe timing
  localparam int PULSE_NS = 10000;
  localparam int PERIOD_MIN_NS = 22000;
  localparam int PERIOD_MAX_NS = 44000;
  localparam int PERIOD_RESET_NS = 26000;
  localparam int GAP_NS = 25;
  localparam int STROBE_NS = 1200;
  localparam int PULSE_CYC = cyc_up(PULSE_NS);
  localparam int PERIOD_MIN_CYC = cyc_up(PERIOD_MIN_NS);
  localparam int PERIOD_MAX_CYC = cyc_down(PERIOD_MAX_NS);
  localparam int PERIOD_RESET_CYC = cyc_up(PERIOD_RESET_NS);
  localparam int GAP_CYC = cyc_down(GAP_NS);
  localparam int STROBE_CYC = cyc_up(STROBE_NS);

  // bit clock is sixteen times the baud rate
  localparam int START_DIV = 16;
  localparam int START_W = 4;
  localparam int DIV_STAGES = 4;

  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  // field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_TXIE_BIT = 3;
  localparam int CTRL_RXIE_BIT = 4;
  localparam int ST_TXE_BIT = 0;
  localparam int ST_RXR_BIT = 1;
  localparam int ST_TXI_BIT = 2;
  localparam int ST_RXI_BIT = 3;
  localparam int ST_DIV_LSB = 4;
  localparam int ST_RUN_BIT = 8;
  localparam int ST_BCLK_BIT = 9;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_RX_BIT = 1;

  // selector positions and reset values
  localparam logic [2:0] SEL_MIN = 3'h1;
  localparam logic [2:0] SEL_MAX = 3'h5;
  localparam logic [2:0] SEL_RESET = 3'h1;

  typedef enum logic [1:0] {OSC_IDLE, OSC_GAP, OSC_RUN} osc_state_type;

endpackage

/* hw/pulse_timer.sv */
// Purpose: non-retriggerable one-shot counting pclk cycles
// Assumes: trigger is a one-cycle request; clear wins over everything
// Notes: active and active_n are both flops so either can feed a port
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
  parameter int WIDTH_CYC = 2000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic trigger,
  // pulse
  output logic active,
  output logic active_n
);
  localparam int CW = $clog2(WIDTH_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(WIDTH_CYC - 1);

  if (WIDTH_CYC < 1) begin : g_bad
    $error("pulse_timer width must be at least one cycle");
  end

  typedef struct packed {
    logic active;
    logic active_n;
    logic [CW-1:0] cnt;
  } timer_type;

  timer_type s;
  timer_type next_s;

  always_comb begin
    next_s = s;
    if (s.active) begin
      if (s.cnt == LAST) begin
        next_s.active = 1'b0;
        next_s.active_n = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end else if (trigger) begin
      next_s.active = 1'b1;
      next_s.active_n = 1'b0;
      next_s.cnt = '0;
    end
    if (clear) begin
      next_s.active = 1'b0;
      next_s.active_n = 1'b1;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{active: 1'b0, active_n: 1'b1, cnt: '0};
    end else begin
      s <= next_s;
    end
  end

  assign active = s.active;
  assign active_n = s.active_n;
endmodule
`default_nettype wire

/* hw/ripple_divider.sv */
// Purpose: binary divider stepped on each falling edge of the base tick
// Assumes: tick is a level synchronous to pclk
// Notes: no preset; clear forces every stage to zero
`timescale 1ns/1ps
`default_nettype none
module ripple_divider #(
  parameter int STAGES = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic tick,
  // divided outputs, bit k is tick / 2**(k+1)
  output logic [STAGES-1:0] q
);
  if (STAGES < 1) begin : g_bad
    $error("ripple_divider needs at least one stage");
  end

  typedef struct packed {
    logic tick_d;
    logic [STAGES-1:0] q;
  } div_type;

  div_type s;
  div_type next_s;

  always_comb begin
    next_s = s;
    next_s.tick_d = tick;
    if (clear) begin
      next_s.q = '0;
    end else if (s.tick_d && !tick) begin
      next_s.q = s.q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{tick_d: 1'b0, q: '0};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule
`default_nettype wire

/* hw/serial_line_baud_clock.sv */
// Purpose: baud clock generation and ready-flag handling for a serial line
// Assumes: all inputs synchronous to pclk; APB slave, one wait state
// Notes: period register replaces the analog trim of the base oscillator
// Behaviour
// - oscillator stopped while init_n low, starts on release, then free-runs
// - every oscillator period begins with a fixed 10 us high tick
// - oscillator period adjustable between about 22 and 44 us
// - after a period times out, a 25 ns gap precedes the next tick
// - period timing starts on the trigger edge; tick starts with period
// - four-stage divider on the base tick gives divide by 2, 4, 8, 16
// - divider cannot be preset and clears while init_n is low
// - selector position 1 gives base tick, 2 to 5 divide by 2 to 16
// - bit clock runs at sixteen times baud; sixteen intervals per bit
// - with local_clock_disable_n low the inverted external clock is used
// - bit clock also drives a counter producing the start tick
// - 26 us period gives 2400 to 150 baud, 35.5 us gives 1760 to 110
// - ready flags clear in the same event that clears their irq flags
// - receive read strobe stretched to one low pulse of about 1.2 us
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module serial_line_baud_clock
  import baud_pkg::*;
#(
  parameter int PERIOD_W = 14,
  parameter int PERIOD_MIN_CYC_P = PERIOD_MIN_CYC,
  parameter int PERIOD_MAX_CYC_P = PERIOD_MAX_CYC,
  parameter int PERIOD_RESET_CYC_P = PERIOD_RESET_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line control
  input wire logic init_n,
  input wire logic local_clock_disable_n,
  input wire logic external_clock_in_n,
  // receiver/transmitter core events
  input wire logic tx_empty_event,
  input wire logic rx_word_event,
  input wire logic tx_buffer_load,
  input wire logic rx_buffer_read,
  // clocks and flags
  output logic base_osc_tick,
  output logic uart_bit_clock,
  output logic start_tick,
  output logic tx_holding_empty,
  output logic rx_word_ready,
  output logic tx_irq_flag,
  output logic rx_irq_flag,
  output logic rx_read_strobe_n,
  output logic irq
);
  localparam logic [PERIOD_W-1:0] GAP_LAST = PERIOD_W'(GAP_CYC - 1);
  localparam logic [PERIOD_W-1:0] PMIN = PERIOD_W'(PERIOD_MIN_CYC_P);
  localparam logic [PERIOD_W-1:0] PMAX = PERIOD_W'(PERIOD_MAX_CYC_P);
  localparam logic [START_W-1:0] START_LAST = START_W'(START_DIV - 1);

  if (PERIOD_MAX_CYC_P >= (1 << PERIOD_W) || PERIOD_MIN_CYC_P <= PULSE_CYC ||
      PERIOD_RESET_CYC_P < PERIOD_MIN_CYC_P || PERIOD_RESET_CYC_P > PERIOD_MAX_CYC_P ||
      (1 << START_W) != START_DIV) begin : g_bad
    $error("serial_line_baud_clock period parameters out of range");
  end

  typedef struct packed {
    osc_state_type osc_state;
    logic [PERIOD_W-1:0] osc_cnt;
    logic [PERIOD_W-1:0] period;
    logic [2:0] sel;
    logic tx_ie;
    logic rx_ie;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic tx_empty;
    logic rx_ready;
    logic tx_irq;
    logic rx_irq;
    logic bit_clk;
    logic [START_W-1:0] start_cnt;
    logic start_tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

  localparam state_type RESET_STATE = '{
    osc_state: OSC_IDLE,
    period: PERIOD_W'(PERIOD_RESET_CYC_P),
    sel: SEL_RESET,
    default: '0
  };

  state_type s;
  state_type next_s;
  logic osc_fire;
  logic sel_clk;
  logic setup;
  logic access;
  logic [DIV_STAGES-1:0] div;
  logic [31:0] status_word;
  logic [1:0] w1c;

  // base tick pulse and stretched receive read strobe
  pulse_timer #(.WIDTH_CYC(PULSE_CYC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!init_n),
    .trigger(osc_fire),
    .active(base_osc_tick),
    .active_n()
  );

  pulse_timer #(.WIDTH_CYC(STROBE_CYC)) u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .clear(1'b0),
    .trigger(rx_buffer_read),
    .active(),
    .active_n(rx_read_strobe_n)
  );

  ripple_divider #(.STAGES(DIV_STAGES)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!init_n),
    .tick(base_osc_tick),
    .q(div)
  );

  always_comb begin
    next_s = s;
    setup = psel && penable && !s.pready;
    access = psel && penable && s.pready;
    osc_fire = init_n && s.osc_state == OSC_GAP && s.osc_cnt == GAP_LAST;
    w1c = '0;

    // base oscillator as a counter on pclk
    case (s.osc_state)
      OSC_IDLE: begin
        next_s.osc_cnt = '0;
        if (init_n) begin
          next_s.osc_state = OSC_GAP;
        end
      end
      OSC_GAP: begin
        if (s.osc_cnt == GAP_LAST) begin
          next_s.osc_state = OSC_RUN;
          next_s.osc_cnt = '0;
        end else begin
          next_s.osc_cnt = s.osc_cnt + 1'b1;
        end
      end
      OSC_RUN: begin
        if (s.osc_cnt >= s.period - 1'b1) begin
          next_s.osc_state = OSC_GAP;
          next_s.osc_cnt = '0;
        end else begin
          next_s.osc_cnt = s.osc_cnt + 1'b1;
        end
      end
      default: begin
        next_s.osc_state = OSC_IDLE;
      end
    endcase
    if (!init_n) begin
      next_s.osc_state = OSC_IDLE;
      next_s.osc_cnt = '0;
    end

    // five-position selector
    case (s.sel)
      3'h1: sel_clk = base_osc_tick;
      3'h2: sel_clk = div[0];
      3'h3: sel_clk = div[1];
      3'h4: sel_clk = div[2];
      3'h5: sel_clk = div[3];
      default: sel_clk = base_osc_tick;
    endcase
    next_s.bit_clk = local_clock_disable_n ? sel_clk : !external_clock_in_n;

    // start timing counter, one tick per sixteen bit clock rises
    next_s.start_tick = 1'b0;
    if (!init_n) begin
      next_s.start_cnt = '0;
    end else if (next_s.bit_clk && !s.bit_clk) begin
      next_s.start_cnt = s.start_cnt + 1'b1;
      next_s.start_tick = (s.start_cnt == START_LAST);
    end

    // ready flags share their clear event with the irq flags
    next_s.tx_empty = tx_empty_event || (s.tx_empty && !tx_buffer_load);
    next_s.tx_irq = (tx_empty_event && s.tx_ie) || (s.tx_irq && !tx_buffer_load);
    next_s.rx_ready = rx_word_event || (s.rx_ready && !rx_buffer_read);
    next_s.rx_irq = (rx_word_event && s.rx_ie) || (s.rx_irq && !rx_buffer_read);

    status_word = '0;
    status_word[ST_TXE_BIT] = s.tx_empty;
    status_word[ST_RXR_BIT] = s.rx_ready;
    status_word[ST_TXI_BIT] = s.tx_irq;
    status_word[ST_RXI_BIT] = s.rx_irq;
    status_word[ST_DIV_LSB +: DIV_STAGES] = div;
    status_word[ST_RUN_BIT] = (s.osc_state != OSC_IDLE);
    status_word[ST_BCLK_BIT] = s.bit_clk;

    // apb: answer one cycle into the access phase
    next_s.pready = setup;
    next_s.pslverr = 1'b0;
    if (setup) begin
      next_s.prdata = '0;
      if (paddr == CTRL_OFS) begin
        next_s.prdata[CTRL_SEL_LSB +: 3] = s.sel;
        next_s.prdata[CTRL_TXIE_BIT] = s.tx_ie;
        next_s.prdata[CTRL_RXIE_BIT] = s.rx_ie;
      end else if (paddr == PERIOD_OFS) begin
        next_s.prdata[PERIOD_W-1:0] = s.period;
      end else if (paddr == STATUS_OFS) begin
        next_s.prdata = status_word;
      end else if (paddr == IRQ_STAT_OFS) begin
        next_s.prdata[1:0] = s.irq_stat;
      end else if (paddr == IRQ_MASK_OFS) begin
        next_s.prdata[1:0] = s.irq_mask;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (access && pwrite) begin
      if (paddr == CTRL_OFS) begin
        if (pwdata[CTRL_SEL_LSB +: 3] >= SEL_MIN && pwdata[CTRL_SEL_LSB +: 3] <= SEL_MAX) begin
          next_s.sel = pwdata[CTRL_SEL_LSB +: 3];
        end
        next_s.tx_ie = pwdata[CTRL_TXIE_BIT];
        next_s.rx_ie = pwdata[CTRL_RXIE_BIT];
      end else if (paddr == PERIOD_OFS) begin
        if (pwdata < 32'(PERIOD_MIN_CYC_P)) begin
          next_s.period = PMIN;
        end else if (pwdata > 32'(PERIOD_MAX_CYC_P)) begin
          next_s.period = PMAX;
        end else begin
          next_s.period = pwdata[PERIOD_W-1:0];
        end
      end else if (paddr == IRQ_STAT_OFS) begin
        w1c = pwdata[1:0];
      end else if (paddr == IRQ_MASK_OFS) begin
        next_s.irq_mask = pwdata[1:0];
      end
    end

    // sticky events, a new event wins over a clear in the same cycle
    next_s.irq_stat = s.irq_stat & ~w1c;
    next_s.irq_stat[IRQ_TX_BIT] = next_s.irq_stat[IRQ_TX_BIT] | tx_empty_event;
    next_s.irq_stat[IRQ_RX_BIT] = next_s.irq_stat[IRQ_RX_BIT] | rx_word_event;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign uart_bit_clock = s.bit_clk;
  assign start_tick = s.start_tick;
  assign tx_holding_empty = s.tx_empty;
  assign rx_word_ready = s.rx_ready;
  assign tx_irq_flag = s.tx_irq;
  assign rx_irq_flag = s.rx_irq;
  assign irq = s.irq;

  // helper counters for pulse-length checks
  logic [15:0] hi_len;
  logic [15:0] lo_len;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_len <= '0;
      lo_len <= '0;
    end else begin
      hi_len <= base_osc_tick ? hi_len + 16'h0001 : 16'h0000;
      lo_len <= !rx_read_strobe_n ? lo_len + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_osc_held_stopped: assert property (!init_n |=> !base_osc_tick && s.osc_state == OSC_IDLE)
    else $error("oscillator running while init_n low");
  chk_tick_width: assert property ($fell(base_osc_tick) && $past(init_n) |-> hi_len == 16'(PULSE_CYC))
    else $error("base tick width wrong");
  chk_period_range: assert property (s.period >= PMIN && s.period <= PMAX)
    else $error("period outside adjustable range");
  chk_gap_before_tick: assert property ($rose(base_osc_tick) |-> $past(s.osc_state) == OSC_GAP && s.osc_state == OSC_RUN)
    else $error("tick not preceded by gap");
  chk_div_step: assert property ($fell(base_osc_tick) && init_n |=> div == $past(div) + 4'h1)
    else $error("divider failed to step");
  chk_div_clear: assert property (!init_n |=> div == 4'h0)
    else $error("divider not cleared");
  chk_sel_base: assert property (local_clock_disable_n && s.sel == 3'h1 |=> uart_bit_clock == $past(base_osc_tick))
    else $error("position 1 does not pass base tick");
  chk_ext_clock: assert property (!local_clock_disable_n |=> uart_bit_clock == !$past(external_clock_in_n))
    else $error("external clock not selected");
  chk_start_spacing: assert property (start_tick |=> !start_tick && s.start_cnt == 4'h0)
    else $error("start tick misplaced");
  chk_tx_clear: assert property (tx_buffer_load && !tx_empty_event |=> !tx_holding_empty && !tx_irq_flag)
    else $error("transmit flags not cleared together");
  chk_rx_clear: assert property (rx_buffer_read && !rx_word_event |=> !rx_word_ready && !rx_irq_flag)
    else $error("receive flags not cleared together");
  chk_strobe_width: assert property ($rose(rx_read_strobe_n) |-> lo_len == 16'(STROBE_CYC))
    else $error("read strobe width wrong");

  cov_tick: cover property ($rose(base_osc_tick));
  cov_start: cover property (start_tick);
  cov_strobe: cover property ($fell(rx_read_strobe_n));
  cov_ext: cover property (!local_clock_disable_n && $rose(uart_bit_clock));
endmodule
`default_nettype wire

/* sim/serial_line_baud_clock_test.sv */
// Purpose: self-checking bench for the serial line baud clock block
// Assumes: shortened minimum oscillator period parameter, pulse widths as built
// Notes: counters sample on the falling edge so they never race the design
`timescale 1ns/1ps
`default_nettype none
module serial_line_baud_clock_test
  import baud_pkg::*;
;
  localparam int PMIN = 2050;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, init_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic local_clock_disable_n, external_clock_in_n, tx_empty_event, rx_word_event;
  logic tx_buffer_load, rx_buffer_read, base_osc_tick, uart_bit_clock, start_tick;
  logic tx_holding_empty, rx_word_ready, tx_irq_flag, rx_irq_flag, rx_read_strobe_n, irq;
  logic e, prev_bc;
  int err_count = 0, num_checks = 0, cycles = 0;
  int bc_rises = 0, starts = 0, hi, lo, n, r0, s0;

  serial_line_baud_clock #(.PERIOD_MIN_CYC_P(PMIN)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .init_n(init_n),
    .local_clock_disable_n(local_clock_disable_n), .external_clock_in_n(external_clock_in_n),
    .tx_empty_event(tx_empty_event), .rx_word_event(rx_word_event),
    .tx_buffer_load(tx_buffer_load), .rx_buffer_read(rx_buffer_read),
    .base_osc_tick(base_osc_tick), .uart_bit_clock(uart_bit_clock), .start_tick(start_tick),
    .tx_holding_empty(tx_holding_empty), .rx_word_ready(rx_word_ready),
    .tx_irq_flag(tx_irq_flag), .rx_irq_flag(rx_irq_flag),
    .rx_read_strobe_n(rx_read_strobe_n), .irq(irq));

  uart_core_model core (.pclk(pclk), .rx_read_strobe_n(rx_read_strobe_n),
    .tx_empty_event(tx_empty_event), .rx_word_event(rx_word_event),
    .tx_buffer_load(tx_buffer_load), .rx_buffer_read(rx_buffer_read),
    .local_clock_disable_n(local_clock_disable_n), .external_clock_in_n(external_clock_in_n));

  always #2.5 pclk = ~pclk;

  always @(negedge pclk) begin
    prev_bc <= uart_bit_clock;
    if (uart_bit_clock === 1'b1 && prev_bc === 1'b0) bc_rises++;
    if (start_tick === 1'b1) starts++;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 100000) begin
      err_count++;
      end_sim;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  function automatic logic sig(input int s);
    return (s == 0) ? base_osc_tick : uart_bit_clock;
  endfunction

  // counts rising edges until the line shows level v
  task wait_sig(input int s, input logic v, output int c);
    c = 0;
    while (sig(s) !== v && c < 40000) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // width of the next complete high phase
  task meas(input int s, output int h);
    wait_sig(s, 1'b0, n);
    wait_sig(s, 1'b1, n);
    wait_sig(s, 1'b0, h);
  endtask

  task reinit;
    init_n <= 1'b0;
    repeat (4) @(posedge pclk);
    init_n <= 1'b1;
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    init_n = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFS, 32'h1);
    rd(PERIOD_OFS, PERIOD_RESET_CYC);
    rd(IRQ_MASK_OFS, 32'h0);
    rd(IRQ_STAT_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0);
    hi = 0;
    repeat (1000) begin
      @(posedge pclk);
      if (base_osc_tick !== 1'b0) hi++;
    end
    check(hi, 0);
    init_n <= 1'b1;
    wait_sig(0, 1'b1, n);
    check(n <= 20, 1);
    meas(0, hi);
    wait_sig(0, 1'b1, lo);
    check(hi, PULSE_CYC);
    check(hi + lo, GAP_CYC + PERIOD_RESET_CYC);
    $display("test oscillator done");
    wr(PERIOD_OFS, 2500);
    rd(PERIOD_OFS, 2500);
    meas(0, hi);
    meas(0, hi);
    wait_sig(0, 1'b1, lo);
    check(hi + lo, GAP_CYC + 2500);
    wr(PERIOD_OFS, 32'h2710);
    rd(PERIOD_OFS, PERIOD_MAX_CYC);
    wr(PERIOD_OFS, 10);
    rd(PERIOD_OFS, PMIN);
    $display("test period done");
    for (int k = 1; k <= 5; k++) begin
      wr(CTRL_OFS, k);
      rd(CTRL_OFS, k);
      reinit;
      meas(1, hi);
      check(hi, (k == 1) ? PULSE_CYC : (GAP_CYC + PMIN) << (k - 2));
    end
    wr(CTRL_OFS, 32'h7);
    rd(CTRL_OFS, 32'h5);
    $display("test selector done");
    core.ext_clock(1);
    check(uart_bit_clock, 1'b1);
    core.ext_clock(1);
    check(uart_bit_clock, 1'b0);
    reinit;
    repeat (8) @(posedge pclk);
    r0 = bc_rises;
    s0 = starts;
    core.ext_clock(128);
    check(bc_rises - r0, 64);
    check(starts - s0, 4);
    core.ext_off;
    $display("test external clock done");
    wr(CTRL_OFS, 32'h19);
    core.pulse(4'h1);
    @(negedge pclk);
    check({tx_holding_empty, tx_irq_flag}, 2'b11);
    core.pulse(4'h5);
    @(negedge pclk);
    check({tx_holding_empty, tx_irq_flag}, 2'b11);
    core.pulse(4'h4);
    @(negedge pclk);
    check({tx_holding_empty, tx_irq_flag}, 2'b00);
    core.pulse(4'h2);
    @(negedge pclk);
    check({rx_word_ready, rx_irq_flag, irq}, 3'b110);
    rd(IRQ_STAT_OFS, 32'h3);
    wr(IRQ_MASK_OFS, 32'h1);
    @(negedge pclk);
    check(irq, 1'b1);
    wr(IRQ_STAT_OFS, 32'h1);
    rd(IRQ_STAT_OFS, 32'h2);
    check(irq, 1'b0);
    wr(IRQ_MASK_OFS, 32'h3);
    rd(IRQ_MASK_OFS, 32'h3);
    check(irq, 1'b1);
    wr(IRQ_STAT_OFS, 32'h2);
    rd(IRQ_STAT_OFS, 32'h0);
    check(irq, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    check(q, 32'h0);
    check(e, 1'b1);
    wr(CTRL_OFS, 32'h1);
    core.pulse(4'h1);
    @(negedge pclk);
    check({tx_holding_empty, tx_irq_flag, irq}, 3'b101);
    $display("test flags done");
    core.pulse(4'h8);
    @(negedge pclk);
    check({rx_word_ready, rx_irq_flag}, 2'b00);
    repeat (300) @(posedge pclk);
    check(core.last_low, STROBE_CYC);
    core.pulse(4'h8);
    repeat (100) @(posedge pclk);
    core.pulse(4'h8);
    repeat (300) @(posedge pclk);
    check(core.last_low, STROBE_CYC);
    $display("test strobe done");
    end_sim;
  end
endmodule
`default_nettype wire

/* sim/uart_core_model.sv */
// Purpose: behavioural receiver/transmitter core on the far side of the baud block
// Assumes: every request starts just after a rising pclk edge
// Notes: also stands in for the external bit clock source
`timescale 1ns/1ps
`default_nettype none
module uart_core_model (
  // clock only
  input wire logic pclk,
  // from the baud block
  input wire logic rx_read_strobe_n,
  // core events
  output logic tx_empty_event,
  output logic rx_word_event,
  output logic tx_buffer_load,
  output logic rx_buffer_read,
  // external clock source
  output logic local_clock_disable_n,
  output logic external_clock_in_n
);
  // length of the last low phase of the read strobe, in pclk cycles
  int run = 0;
  int last_low = 0;

  always @(negedge pclk) begin
    if (rx_read_strobe_n === 1'b0) begin
      run++;
    end else if (run > 0) begin
      last_low = run;
      run = 0;
    end
  end

  initial begin
    {rx_buffer_read, tx_buffer_load, rx_word_event, tx_empty_event} = 4'h0;
    local_clock_disable_n = 1'b1;
    external_clock_in_n = 1'b1;
  end

  // one-cycle pulses; bit order read, load, word, empty
  task pulse(input logic [3:0] m);
    @(posedge pclk);
    {rx_buffer_read, tx_buffer_load, rx_word_event, tx_empty_event} <= m;
    @(posedge pclk);
    {rx_buffer_read, tx_buffer_load, rx_word_event, tx_empty_event} <= 4'h0;
    @(posedge pclk);
  endtask

  // take over the bit clock and toggle it n times, four pclk per phase
  task ext_clock(input int n);
    local_clock_disable_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge pclk);
      external_clock_in_n <= ~external_clock_in_n;
    end
    repeat (4) @(posedge pclk);
  endtask

  task ext_off;
    local_clock_disable_n <= 1'b1;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire
